// file: rtl/cct_channel_timer_array.sv
`timescale 1ns/1ps
`include "cct_map.svh"
module cct_channel_timer_array #(
    parameter int NCH   = `CCT_NCH,
    parameter int W     = `CCT_TW,
    parameter int PRE_W = `CCT_PRE_W
) (
    // clock and reset
    input  logic                           clk,
    input  logic                           rst_n,
    // operating option
    input  logic                           stagger_en,
    // timers
    input  logic [1:0]                     tmr_run,
    input  cct_pkg::cct_src_t [1:0]        tmr_src,
    input  logic [1:0][2:0]                tmr_pre,
    input  logic [1:0][W-1:0]              tmr_reload,
    input  logic                           aux_ovf,
    input  logic [1:0]                     ext_cnt_pin,
    output logic [1:0][W-1:0]              tmr_cnt,
    // channel configuration
    input  cct_pkg::cct_mode_t [NCH-1:0]   ch_mode,
    input  logic [NCH-1:0]                 ch_tsel,
    input  cct_pkg::cct_edge_t [NCH-1:0]   ch_edge,
    input  logic [NCH-1:0]                 ch_oneshot,
    input  logic [NCH/2-1:0]               dbl_en,
    // channel register write
    input  logic [NCH-1:0]                 ch_wr,
    input  logic [W-1:0]                   ch_wdata,
    output logic [NCH-1:0][W-1:0]          ch_val,
    // channel pins
    input  logic [NCH-1:0]                 pin_in,
    output logic [NCH-1:0]                 pin_out,
    output logic [NCH-1:0]                 pin_oe,
    // channel events
    output logic [NCH-1:0]                 ch_irq
);

    localparam int HALF = NCH / 2;

    typedef struct packed {
        logic [2:0]            stg;
        logic [NCH-1:0][W-1:0] val;
        logic [NCH-1:0]        pin;
        logic [NCH-1:0]        fired;
        logic [NCH-1:0]        done;
        logic [NCH-1:0]        irq;
    } cct_arr_state_t;

    cct_arr_state_t        s_q, s_d;
    logic                  stb;
    logic [1:0]            tstep_t;
    logic [1:0]            tovf_t;
    logic [NCH+1:0]        rs_rise;
    logic [NCH+1:0]        rs_fall;
    logic [NCH-1:0][W-1:0] tval;
    logic [NCH-1:0]        tstep;
    logic [NCH-1:0]        tovf;
    logic [NCH-1:0]        is_cmp;
    logic [NCH-1:0]        once;
    logic [NCH-1:0]        match;
    logic [NCH-1:0]        ev;
    logic [NCH-1:0]        cap_ev;
    logic [NCH-1:0]        paired;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // staggered slot strobe
    assign stb = ~stagger_en | (s_q.stg == `CCT_STG_LAST);

    // pin and count input synchronisers
    cct_sync #(
        .W(NCH + 2)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   ({ext_cnt_pin, pin_in}),
        .rise  (rs_rise),
        .fall  (rs_fall)
    );

    // two time bases
    genvar t;
    for (t = 0; t < 2; t++) begin : g_tmr
        cct_timer #(
            .W     (W),
            .PRE_W (PRE_W)
        ) u_tmr (
            .clk     (clk),
            .rst_n   (rst_n),
            .run     (tmr_run[t]),
            .src     (tmr_src[t]),
            .pre_sel (tmr_pre[t]),
            .stb     (stb),
            .aux_ovf (aux_ovf),
            .ext_cnt (rs_rise[NCH+t]),
            .reload  (tmr_reload[t]),
            .cnt     (tmr_cnt[t]),
            .step    (tstep_t[t]),
            .ovf     (tovf_t[t])
        );
    end

    // per channel decode
    genvar i;
    for (i = 0; i < NCH; i++) begin : g_ch
        logic drv;
        assign tval[i]   = tmr_cnt[ch_tsel[i]];
        assign tstep[i]  = tstep_t[ch_tsel[i]];
        assign tovf[i]   = tovf_t[ch_tsel[i]];
        assign is_cmp[i] = ch_mode[i] inside {cct_pkg::cct_cmp0, cct_pkg::cct_cmp1,
                                              cct_pkg::cct_cmp2, cct_pkg::cct_cmp3};
        assign once[i]   = ch_mode[i] inside {cct_pkg::cct_cmp2, cct_pkg::cct_cmp3};
        assign match[i]  = is_cmp[i] & tstep[i] & (tval[i] == s_q.val[i]);
        assign ev[i]     = match[i] & ~s_q.done[i] & ~(once[i] & s_q.fired[i]);
        assign cap_ev[i] = (ch_mode[i] == cct_pkg::cct_cap)
                         & ((rs_rise[i] & (ch_edge[i] != cct_pkg::cct_edge_fall))
                          | (rs_fall[i] & (ch_edge[i] != cct_pkg::cct_edge_rise)));
        assign drv       = ch_mode[i] inside {cct_pkg::cct_cmp1, cct_pkg::cct_cmp3};
        assign ch_val[i] = s_q.val[i];
        if (i < HALF) begin : g_lo
            assign paired[i] = dbl_en[i];
            assign pin_oe[i] = dbl_en[i] | drv;
            a_pair_toggle: assert property (dbl_en[i] && (ev[i] ^ ev[i+HALF])
                |=> pin_out[i] != $past(pin_out[i]))
                else $error("paired pin did not toggle");
        end else begin : g_hi
            assign paired[i] = dbl_en[i-HALF];
            assign pin_oe[i] = ~dbl_en[i-HALF] & drv;
            a_pair_hold: assert property (dbl_en[i-HALF] |=> $stable(pin_out[i]))
                else $error("paired upper pin moved");
        end

        a_cap_no_drive: assert property (ch_mode[i] == cct_pkg::cct_cap |-> !pin_oe[i])
            else $error("capture pin driven");
        a_write_load: assert property (ch_wr[i] && !cap_ev[i] |=> s_q.val[i] == $past(ch_wdata))
            else $error("channel write not taken");
        a_off_quiet: assert property (ch_mode[i] == cct_pkg::cct_off |=> !ch_irq[i])
            else $error("disabled channel raised an interrupt");
        a_irq_cause: assert property (ch_irq[i] |-> $past(cap_ev[i] || ev[i]))
            else $error("interrupt without an event");

        a_cap_load: assert property (cap_ev[i] |=> s_q.val[i] == $past(tval[i]))
            else $error("capture did not latch timer value");
        a_cap_irq: assert property (cap_ev[i] |=> ch_irq[i] ##1 !ch_irq[i] || $past(cap_ev[i]) || $past(ev[i]))
            else $error("capture interrupt missing");
        a_edge_sel: assert property (ch_mode[i] == cct_pkg::cct_cap
            && ch_edge[i] == cct_pkg::cct_edge_rise && rs_fall[i] |=> !ch_irq[i])
            else $error("falling edge captured in rising mode");
        a_mode0_pin: assert property (ch_mode[i] == cct_pkg::cct_cmp0 && !paired[i]
            |-> !pin_oe[i] ##1 $stable(pin_out[i]))
            else $error("mode 0 touched the pin");
        a_mode1_tog: assert property (ch_mode[i] == cct_pkg::cct_cmp1 && !paired[i] && ev[i]
            |=> pin_out[i] != $past(pin_out[i]) && ch_irq[i])
            else $error("mode 1 pin did not toggle");
        a_mode2_once: assert property (ch_mode[i] == cct_pkg::cct_cmp2 && s_q.fired[i]
            && !tovf[i] && match[i] |=> !ch_irq[i])
            else $error("second mode 2 interrupt in one period");
        a_mode3_set: assert property (ch_mode[i] == cct_pkg::cct_cmp3 && !paired[i] && ev[i]
            |=> pin_out[i])
            else $error("mode 3 pin not set on match");
        a_mode3_clr: assert property (ch_mode[i] == cct_pkg::cct_cmp3 && !paired[i]
            && tovf[i] && !ev[i] |=> !pin_out[i])
            else $error("mode 3 pin not cleared on overflow");
        a_oneshot_stop: assert property (ch_oneshot[i] && ev[i]
            ##1 (is_cmp[i] && !cap_ev[i]) |=> !ch_irq[i])
            else $error("one-shot channel fired again");
    end

    a_stagger_res: assert property (stagger_en && $past(stagger_en) && |tstep_t
        |-> $past(s_q.stg) == `CCT_STG_LAST)
        else $error("timer stepped outside the stagger slot");

    c_capture: cover property (cap_ev[0] ##1 ch_irq[0]);
    c_mode1_tog: cover property (ch_mode[0] == cct_pkg::cct_cmp1 && ev[0]);
    c_mode3_cycle: cover property (ch_mode[0] == cct_pkg::cct_cmp3 && ev[0] ##[1:300] tovf[0]);
    c_pair: cover property (dbl_en[0] && ev[HALF]);
    c_mode2_block: cover property (ch_mode[0] == cct_pkg::cct_cmp2 && s_q.fired[0] && match[0]);

    // compare pin action for unpaired channels
    function automatic logic cct_pin_next(input cct_pkg::cct_mode_t m,
                                          input logic e,
                                          input logic o,
                                          input logic p);
        case (m)
            cct_pkg::cct_cmp1: cct_pin_next = p ^ e;
            cct_pkg::cct_cmp3: cct_pin_next = e ? 1'b1 : (o ? 1'b0 : p);
            default:           cct_pin_next = p;
        endcase
    endfunction : cct_pin_next

    always_comb begin
        s_d     = s_q;
        s_d.stg = stagger_en ? s_q.stg + 3'h1 : `CCT_STG_RST;
        for (int c = 0; c < NCH; c++) begin
            s_d.irq[c] = cap_ev[c] | ev[c];
            if (ch_wr[c]) begin
                s_d.val[c]  = ch_wdata;
                s_d.done[c] = 1'b0;
            end
            if (cap_ev[c]) begin
                s_d.val[c] = tval[c];
            end
            s_d.fired[c] = (s_q.fired[c] & ~tovf[c]) | ev[c];
            if (ev[c] & ch_oneshot[c]) begin
                s_d.done[c] = 1'b1;
            end
        end
        for (int k = 0; k < HALF; k++) begin
            if (dbl_en[k]) begin
                s_d.pin[k] = s_q.pin[k] ^ ev[k] ^ ev[k+HALF];
            end else begin
                s_d.pin[k] = cct_pin_next(ch_mode[k], ev[k], tovf[k], s_q.pin[k]);
            end
        end
        for (int k = HALF; k < NCH; k++) begin
            if (!dbl_en[k-HALF]) begin
                s_d.pin[k] = cct_pin_next(ch_mode[k], ev[k], tovf[k], s_q.pin[k]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q.stg   <= `CCT_STG_RST;
            s_q.val   <= {NCH{W'(`CCT_RST_VAL)}};
            s_q.pin   <= '0;
            s_q.fired <= '0;
            s_q.done  <= '0;
            s_q.irq   <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_out = s_q.pin;
    assign ch_irq  = s_q.irq;

endmodule : cct_channel_timer_array

// file: include/cct_map.svh
`ifndef CCT_MAP_SVH
`define CCT_MAP_SVH

// default sizes
`define CCT_NCH      16
`define CCT_TW       16
`define CCT_PRE_W    8

// staggered slot counter
`define CCT_STG_LAST 3'h7
`define CCT_STG_RST  3'h0

// reset values
`define CCT_RST_VAL  16'h0000
`define CCT_RST_CNT  16'h0000
`define CCT_RST_DIV  8'h00

`endif

// file: include/cct_pkg.sv
package cct_pkg;

    // channel function
    typedef enum logic [2:0] {
        cct_off,
        cct_cap,
        cct_cmp0,
        cct_cmp1,
        cct_cmp2,
        cct_cmp3
    } cct_mode_t;

    // capture edge
    typedef enum logic [1:0] {
        cct_edge_rise,
        cct_edge_fall,
        cct_edge_both
    } cct_edge_t;

    // timer count source
    typedef enum logic [1:0] {
        cct_src_pre,
        cct_src_aux,
        cct_src_ext
    } cct_src_t;

endpackage : cct_pkg

// file: rtl/cct_sync.sv
`timescale 1ns/1ps
module cct_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  logic         clk,
    input  logic         rst_n,
    // raw pins
    input  logic [W-1:0] pin,
    // filtered edges
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
        logic [W-1:0] rise;
        logic [W-1:0] fall;
    } cct_sync_state_t;

    cct_sync_state_t s_q, s_d;
    logic [W-1:0]    agree;

    // level accepted once stages two and three agree
    always_comb begin
        s_d      = s_q;
        s_d.s1   = pin;
        s_d.s2   = s_q.s1;
        s_d.s3   = s_q.s2;
        agree    = ~(s_q.s2 ^ s_q.s3);
        s_d.lvl  = (agree & s_q.s2) | (~agree & s_q.lvl);
        s_d.rise = s_d.lvl & ~s_q.lvl;
        s_d.fall = ~s_d.lvl & s_q.lvl;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rise = s_q.rise;
    assign fall = s_q.fall;

endmodule : cct_sync

// file: rtl/cct_timer.sv
`timescale 1ns/1ps
`include "cct_map.svh"
module cct_timer #(
    parameter int W     = `CCT_TW,
    parameter int PRE_W = `CCT_PRE_W
) (
    // clock and reset
    input  logic              clk,
    input  logic              rst_n,
    // count source
    input  logic              run,
    input  cct_pkg::cct_src_t src,
    input  logic [2:0]        pre_sel,
    input  logic              stb,
    input  logic              aux_ovf,
    input  logic              ext_cnt,
    input  logic [W-1:0]      reload,
    // timer state
    output logic [W-1:0]      cnt,
    output logic              step,
    output logic              ovf
);

    typedef struct packed {
        logic [PRE_W-1:0] div;
        logic             pend;
        logic [W-1:0]     cnt;
        logic             step;
        logic             ovf;
    } cct_tmr_state_t;

    cct_tmr_state_t   s_q, s_d;
    logic [PRE_W-1:0] mask;
    logic             ev;
    logic             tick;

    always_comb begin
        s_d   = s_q;
        mask  = ~({PRE_W{1'b1}} << pre_sel);
        ev    = 1'b0;
        tick  = 1'b0;
        if (stb) begin
            s_d.div = s_q.div + 1'b1;
        end
        case (src)
            cct_pkg::cct_src_pre: tick = stb & ((s_q.div & mask) == mask);
            cct_pkg::cct_src_aux: ev = aux_ovf;
            cct_pkg::cct_src_ext: ev = ext_cnt;
            default:              ev = 1'b0;
        endcase
        // event sources wait for the next slot
        if (src != cct_pkg::cct_src_pre) begin
            tick     = stb & (s_q.pend | ev);
            s_d.pend = ~stb & (s_q.pend | ev);
        end
        tick     = tick & run;
        s_d.step = tick;
        s_d.ovf  = 1'b0;
        if (tick) begin
            if (s_q.cnt == {W{1'b1}}) begin
                s_d.cnt = reload;
                s_d.ovf = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q.div  <= PRE_W'(`CCT_RST_DIV);
            s_q.pend <= 1'b0;
            s_q.cnt  <= W'(`CCT_RST_CNT);
            s_q.step <= 1'b0;
            s_q.ovf  <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cnt  = s_q.cnt;
    assign step = s_q.step;
    assign ovf  = s_q.ovf;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_reload_wrap: assert property (tick && s_q.cnt == {W{1'b1}} |=> cnt == $past(reload) && ovf)
        else $error("timer did not reload on overflow");
    a_count_step: assert property (tick && s_q.cnt != {W{1'b1}} |=> (cnt - $past(cnt)) == W'(1) && !ovf)
        else $error("timer did not advance by one");
    a_hold_idle: assert property (!tick |=> $stable(cnt) && !step)
        else $error("timer moved without a count tick");

endmodule : cct_timer

// file: tb/cct_pin_model.sv
`timescale 1ns/1ps
module cct_pin_model (
    // clock
    input  logic        clk,
    // levels asked for by the bench
    input  logic [15:0] want,
    // design side of the pins
    input  logic [15:0] pin_out,
    input  logic [15:0] pin_oe,
    // resolved pin level
    output logic [15:0] pin_lvl
);
    logic [15:0] ext_q;
    // external source moves only on an edge and holds its level
    always_ff @(posedge clk) begin
        ext_q <= want;
    end
    // driven pins carry the design level, the others the external source
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_q);
endmodule : cct_pin_model

// file: tb/cct_channel_timer_array_bench.sv
`timescale 1ns/1ps
module cct_channel_timer_array_bench;
    localparam logic [15:0] RLD = 16'hFFF0;
    logic                        clk = 1'b0;
    logic                        rst_n = 1'b0;
    logic                        stagger_en, aux_ovf;
    logic [1:0]                  tmr_run, ext_cnt_pin;
    cct_pkg::cct_src_t [1:0]     tmr_src;
    logic [1:0][2:0]             tmr_pre;
    logic [1:0][15:0]            tmr_reload, tmr_cnt;
    cct_pkg::cct_mode_t [15:0]   ch_mode;
    cct_pkg::cct_edge_t [15:0]   ch_edge;
    logic [15:0]                 ch_tsel, ch_oneshot, ch_wr, ch_wdata;
    logic [7:0]                  dbl_en;
    logic [15:0][15:0]           ch_val;
    logic [15:0]                 want, pin_lvl, pin_out, pin_oe, ch_irq;
    logic [15:0]                 lfsr_q = 16'h0018;
    logic [15:0]                 t1, prev;
    int                          error_cnt = 0;
    int                          total_checks = 0;
    int                          cycles = 0;
    int                          c, n, irqs, tgl;

    always #4 clk = ~clk;

    cct_channel_timer_array cct_channel_timer_array_inst (
        .clk(clk), .rst_n(rst_n), .stagger_en(stagger_en), .tmr_run(tmr_run),
        .tmr_src(tmr_src), .tmr_pre(tmr_pre), .tmr_reload(tmr_reload),
        .aux_ovf(aux_ovf), .ext_cnt_pin(ext_cnt_pin), .tmr_cnt(tmr_cnt),
        .ch_mode(ch_mode), .ch_tsel(ch_tsel), .ch_edge(ch_edge),
        .ch_oneshot(ch_oneshot), .dbl_en(dbl_en), .ch_wr(ch_wr),
        .ch_wdata(ch_wdata), .ch_val(ch_val), .pin_in(pin_lvl),
        .pin_out(pin_out), .pin_oe(pin_oe), .ch_irq(ch_irq)
    );

    cct_pin_model cct_pin_model_inst (
        .clk(clk), .want(want), .pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl)
    );

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr_next

    function automatic int exp_tgl(input cct_pkg::cct_mode_t m, input logic os);
        if (m == cct_pkg::cct_cmp1) begin
            return os ? 1 : 4;
        end
        return (m == cct_pkg::cct_cmp3) ? 8 : 0;
    endfunction : exp_tgl

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic check_cnt(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            error_cnt++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_cnt

    task automatic count_ev(input int ch, input int cyc, output int ni, output int nt);
        logic last;
        ni = 0;
        nt = 0;
        last = pin_out[ch];
        repeat (cyc) begin
            step();
            ni += int'(ch_irq[ch] === 1'b1);
            nt += int'(pin_out[ch] !== last);
            last = pin_out[ch];
        end
    endtask : count_ev

    task automatic cap_once(input int ch, input logic lv, input logic hit);
        logic [15:0] wv;
        wv = ~t1;
        ch_wdata = wv;
        ch_wr[ch] = 1'b1;
        aux_ovf = 1'b1;
        step();
        ch_wr[ch] = 1'b0;
        aux_ovf = 1'b0;
        t1 = t1 + 16'h0001;
        want[ch] = lv;
        count_ev(ch, 10, irqs, tgl);
        check_cnt("capture irq", int'(hit), irqs);
        check_val("capture value", hit ? t1 : wv, ch_val[ch]);
        check_val("capture oe", 16'h0000, {15'h0000, pin_oe[ch]});
    endtask : cap_once

    task automatic run_cmp(input cct_pkg::cct_mode_t m, input logic os);
        int k;
        lfsr_q = lfsr_next(lfsr_q);
        c = int'(lfsr_q[3:0]);
        k = int'(lfsr_q[7:4]) % 14 + 1;
        for (int r = 0; r <= int'(os); r++) begin
            ch_mode[c] = cct_pkg::cct_off;
            step();
            ch_mode[c] = m;
            ch_tsel[c] = 1'b0;
            ch_oneshot[c] = os;
            ch_wdata = RLD + 16'(k);
            ch_wr[c] = 1'b1;
            step();
            ch_wr[c] = 1'b0;
            if (!os) begin
                repeat (20) step();
            end
            count_ev(c, os ? 90 : 64, irqs, tgl);
            check_cnt("compare irq", os ? 1 : 4, irqs);
            check_cnt("compare toggles", exp_tgl(m, os), tgl);
        end
        check_val("compare oe", {15'h0000, m inside {cct_pkg::cct_cmp1, cct_pkg::cct_cmp3}},
                  {15'h0000, pin_oe[c]});
        ch_mode[c] = cct_pkg::cct_off;
        ch_oneshot[c] = 1'b0;
    endtask : run_cmp

    initial begin
        stagger_en = 1'b0;
        aux_ovf = 1'b0;
        tmr_run = 2'b10;
        ext_cnt_pin = 2'b00;
        tmr_src[0] = cct_pkg::cct_src_pre;
        tmr_src[1] = cct_pkg::cct_src_aux;
        tmr_pre = 6'h00;
        tmr_reload = {16'h0000, RLD};
        ch_tsel = 16'h0000;
        ch_oneshot = 16'h0000;
        ch_wr = 16'h0000;
        ch_wdata = 16'h0000;
        dbl_en = 8'h00;
        want = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            ch_mode[i] = cct_pkg::cct_off;
            ch_edge[i] = cct_pkg::cct_edge_rise;
        end
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        step();
        check_val("reset count", 16'h0000, tmr_cnt[1]);
        t1 = 16'(lfsr_q[3:0]) + 16'h0001;
        repeat (int'(t1)) begin
            aux_ovf = 1'b1;
            step();
            aux_ovf = 1'b0;
            step();
        end
        step();
        check_val("aux count", t1, tmr_cnt[1]);
        tmr_src[1] = cct_pkg::cct_src_ext;
        repeat (3) begin
            ext_cnt_pin[1] = 1'b1;
            repeat (6) step();
            ext_cnt_pin[1] = 1'b0;
            repeat (6) step();
        end
        t1 = t1 + 16'h0003;
        check_val("ext count", t1, tmr_cnt[1]);
        tmr_src[1] = cct_pkg::cct_src_aux;
        for (int e = 0; e < 3; e++) begin
            lfsr_q = lfsr_next(lfsr_q);
            c = int'(lfsr_q[3:0]);
            ch_mode[c] = cct_pkg::cct_cap;
            ch_tsel[c] = 1'b1;
            ch_edge[c] = cct_pkg::cct_edge_t'(e);
            cap_once(c, 1'b1, e != 1);
            cap_once(c, 1'b0, e != 0);
            ch_mode[c] = cct_pkg::cct_off;
        end
        tmr_run[0] = 1'b1;
        n = 0;
        while (tmr_cnt[0] !== 16'hFFFF && n < 70000) begin
            step();
            n++;
        end
        step();
        check_val("reload", RLD, tmr_cnt[0]);
        step();
        check_val("count up", RLD + 16'h0001, tmr_cnt[0]);
        for (n = 0; n < 6; n++) begin
            tmr_pre[0] = (n < 5) ? 3'(n) : 3'h0;
            stagger_en = (n == 5);
            repeat (20) step();
            tgl = 0;
            repeat (80) begin
                prev = tmr_cnt[0];
                step();
                tgl += int'(tmr_cnt[0] !== prev);
            end
            check_cnt("timer steps", (n == 5) ? 10 : (80 >> n), tgl);
        end
        stagger_en = 1'b0;
        tmr_pre[0] = 3'h0;
        for (int m = 2; m < 6; m++) begin
            run_cmp(cct_pkg::cct_mode_t'(m), 1'b0);
        end
        for (int m = 2; m < 5; m++) begin
            run_cmp(cct_pkg::cct_mode_t'(m), 1'b1);
        end
        for (int m = 2; m < 5; m += 2) begin
            lfsr_q = lfsr_next(lfsr_q);
            c = int'(lfsr_q[3:0]);
            ch_mode[c] = cct_pkg::cct_mode_t'(m);
            ch_tsel[c] = 1'b0;
            ch_wdata = RLD + 16'h0002;
            ch_wr[c] = 1'b1;
            step();
            ch_wr[c] = 1'b0;
            n = 0;
            while (ch_irq[c] !== 1'b1 && n < 40) begin
                step();
                n++;
            end
            check_cnt("first match wait", 1, int'(n < 40));
            ch_wdata = RLD + 16'h000C;
            ch_wr[c] = 1'b1;
            step();
            ch_wr[c] = 1'b0;
            count_ev(c, 10, irqs, tgl);
            check_cnt("rewrite irq", (m == 2) ? 1 : 0, irqs);
            ch_mode[c] = cct_pkg::cct_off;
        end
        lfsr_q = lfsr_next(lfsr_q);
        c = int'(lfsr_q[2:0]);
        dbl_en[c] = 1'b1;
        ch_mode[c] = cct_pkg::cct_cmp1;
        ch_mode[c + 8] = cct_pkg::cct_cmp1;
        ch_tsel[c] = 1'b0;
        ch_tsel[c + 8] = 1'b0;
        ch_wdata = RLD + 16'h0003;
        ch_wr[c] = 1'b1;
        step();
        ch_wr[c] = 1'b0;
        ch_wdata = RLD + 16'h0009;
        ch_wr[c + 8] = 1'b1;
        step();
        ch_wr[c + 8] = 1'b0;
        repeat (20) step();
        count_ev(c, 64, irqs, tgl);
        check_cnt("paired toggles", 8, tgl);
        check_val("paired oe", 16'h0000, {15'h0000, pin_oe[c + 8]});
        check_val("paired drive", 16'h0001, {15'h0000, pin_oe[c]});
        final_report();
    end
endmodule : cct_channel_timer_array_bench
